// file: design/lcd_clock_select.sv
`timescale 1ns/1ps
module lcd_clock_select
  import lcd_clk_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  // AXI4-Lite slave
  input  wire logic [HOST_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [HOST_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Clock source pins and straps
  input  wire logic                   primary_clock_input,
  input  wire logic                   secondary_clock_input,
  input  wire logic                   crystal_osc_input,
  input  wire logic [1:0]             strap_divider_select,
  // Host select pins
  input  wire logic                   chip_select_n,
  input  wire logic                   mem_reg_select_n,
  input  wire logic [HOST_ADDR_W-1:0] host_addr,
  // Derived clock enables and outputs
  output logic                        bus_clk_en,
  output logic                        mem_clk_en,
  output logic                        pix_clk_en,
  output logic                        pulse_mod_clock,
  output logic                        pulse_mod_output,
  output logic                        reg_space_sel,
  output logic [HOST_ADDR_W-1:0]      reg_space_addr
);
  localparam int PIN_W = HOST_ADDR_W + 7;
  // Select pins rest high, so reset leaves the synchronised selects idle, not a false select
  localparam logic [PIN_W-1:0] PIN_IDLE = PIN_W'(7'h60);

  // Pin synchronisers: meta stage read only by the second stage
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic [2:0]       clk_prev_reg;

  assign pin_raw = {host_addr, mem_reg_select_n, chip_select_n, strap_divider_select,
                    crystal_osc_input, secondary_clock_input, primary_clock_input};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          pin_meta_reg[gi] <= PIN_IDLE[gi];
          pin_sync_reg[gi] <= PIN_IDLE[gi];
        end
        else
        begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  logic                   pri_s;
  logic                   sec_pin_s;
  logic                   crystal_osc_input_s;
  logic [1:0]             strap_s;
  logic                   cs_n_s;
  logic                   mr_n_s;
  logic [HOST_ADDR_W-1:0] addr_s;
  logic                   pri_edge;
  logic                   sec_edge;
  logic                   crystal_osc_input_edge;

  assign pri_s     = pin_sync_reg[0];
  assign sec_pin_s = pin_sync_reg[1];
  assign crystal_osc_input_s    = pin_sync_reg[2];
  assign strap_s   = pin_sync_reg[4:3];
  assign cs_n_s    = pin_sync_reg[5];
  assign mr_n_s    = pin_sync_reg[6];
  assign addr_s    = pin_sync_reg[PIN_W-1:7];
  // Rising edges of the synchronised clock pins act as source pulses
  assign pri_edge  = pri_s && !clk_prev_reg[0];
  assign sec_edge  = sec_pin_s && !clk_prev_reg[1];
  assign crystal_osc_input_edge = crystal_osc_input_s && !clk_prev_reg[2];

  always_ff @(posedge clk)
  begin
    if (rst)
      clk_prev_reg <= '0;
    else
      clk_prev_reg <= {crystal_osc_input_s, sec_pin_s, pri_s};
  end

  // Strap capture after release, once the synchroniser has filled
  logic [1:0] strap_reg;
  logic [1:0] strap_wait_reg;
  logic       strap_done_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      strap_reg      <= 2'h0;
      strap_wait_reg <= 2'h0;
      strap_done_reg <= 1'b0;
    end
    else if (!strap_done_reg)
    begin
      strap_wait_reg <= 2'(strap_wait_reg + 2'h1);
      if (strap_wait_reg == STRAP_WAIT)
      begin
        strap_reg      <= strap_s;
        strap_done_reg <= 1'b1;
      end
    end
  end

  // Software registers
  logic [7:0] mem_cfg_reg;
  logic [7:0] pix_cfg_reg;
  logic [7:0] pulse_cfg_reg;
  logic [7:0] src_sel_reg;
  logic [7:0] fn_en_reg;
  logic [7:0] duty_reg;

  // Which clock each function needs; panel output needs no bus clock
  logic reg_busy;
  logic bus_need;
  logic mem_need;
  logic pix_need;
  logic pulse_need;

  assign reg_busy   = s_axi_awvalid || s_axi_arvalid || s_axi_bvalid || s_axi_rvalid;
  assign bus_need   = reg_busy || fn_en_reg[FN_MEM_BIT] || fn_en_reg[FN_LUT_BIT]
                      || fn_en_reg[FN_PSAVE_BIT];
  assign mem_need   = fn_en_reg[FN_MEM_BIT] || fn_en_reg[FN_LUT_BIT] || fn_en_reg[FN_PANEL_BIT];
  assign pix_need   = fn_en_reg[FN_PANEL_BIT];
  assign pulse_need = fn_en_reg[FN_PULSE_BIT];

  // Source selection and divider ratios
  logic       bus_src;
  logic       sec_src;
  logic       pix_src;
  logic       pulse_src;
  logic [3:0] bus_ratio;
  logic [3:0] mem_ratio;
  logic [3:0] pix_ratio;
  logic [3:0] pix_code;
  logic [3:0] pix_sel;
  logic       bus_raw;
  logic       mem_raw;
  logic [3:0] bus_now;
  logic [3:0] pix_now;
  logic [3:0] pulse_now;
  logic       pulse_tick;

  assign bus_src   = src_sel_reg[BUS_SRC_BIT] ? crystal_osc_input_edge : pri_edge;
  assign sec_src   = src_sel_reg[SEC_SRC_BIT] ? crystal_osc_input_edge : sec_edge;
  assign pix_sel   = pix_cfg_reg[PIX_SRC_LSB +: 4];
  assign pix_code  = pix_cfg_reg[PIX_DIV_LSB +: 4];
  assign pix_src   = (pix_sel == PIX_SRC_MEM) ? mem_raw :
                     (pix_sel == PIX_SRC_BUS) ? bus_raw :
                     (pix_sel == PIX_SRC_PRI) ? pri_edge :
                     (pix_sel == PIX_SRC_SEC) ? sec_src : 1'b0;
  assign pulse_src = pulse_cfg_reg[PULSE_SRC_BIT] ? sec_src : pri_edge;
  // Bus divider stays at one until the strap has been taken
  assign bus_ratio = strap_done_reg ? 4'({2'h0, strap_reg} + 4'h1) : 4'h1;
  assign mem_ratio = 4'({2'h0, mem_cfg_reg[MEM_DIV_LSB +: 2]} + 4'h1);
  assign pix_ratio = (pix_code <= PIX_DIV_CODE_MAX) ? 4'(pix_code + 4'h1) :
                     (pix_code == PIX_DIV_CODE_8) ? PIX_DIV_8 : 4'h1;

  // Memory and pixel chains run from ungated pulses so gating upstream never starves them
  clk_div_tick #(.CW(4)) u_bus_div (
    .clk       (clk),
    .rst       (rst),
    .src_tick  (bus_src),
    .ratio_req (bus_ratio),
    .gate_en   (bus_need),
    .tick_q    (bus_clk_en),
    .raw_q     (bus_raw),
    .ratio_now (bus_now)
  );

  clk_div_tick #(.CW(4)) u_mem_div (
    .clk       (clk),
    .rst       (rst),
    .src_tick  (bus_raw),
    .ratio_req (mem_ratio),
    .gate_en   (mem_need),
    .tick_q    (mem_clk_en),
    .raw_q     (mem_raw),
    .ratio_now ()
  );

  clk_div_tick #(.CW(4)) u_pix_div (
    .clk       (clk),
    .rst       (rst),
    .src_tick  (pix_src),
    .ratio_req (pix_ratio),
    .gate_en   (pix_need),
    .tick_q    (pix_clk_en),
    .raw_q     (),
    .ratio_now (pix_now)
  );

  // Modulator clock undivided; enable only gates it
  clk_div_tick #(.CW(4)) u_pulse_div (
    .clk       (clk),
    .rst       (rst),
    .src_tick  (pulse_src),
    .ratio_req (4'h1),
    .gate_en   (pulse_need),
    .tick_q    (pulse_tick),
    .raw_q     (),
    .ratio_now (pulse_now)
  );

  // Backlight modulator; held low while its clock is gated
  logic [7:0] pwm_cnt_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pwm_cnt_reg      <= 8'h00;
      pulse_mod_output <= 1'b0;
      pulse_mod_clock  <= 1'b0;
    end
    else
    begin
      pulse_mod_clock <= pulse_tick;
      if (!pulse_need)
        pulse_mod_output <= 1'b0;
      else if (pulse_tick)
      begin
        pwm_cnt_reg      <= 8'(pwm_cnt_reg + 8'h01);
        pulse_mod_output <= (pwm_cnt_reg < duty_reg);
      end
    end
  end

  // Register space decode from the host select pins
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_space_sel  <= 1'b0;
      reg_space_addr <= '0;
    end
    else
    begin
      reg_space_sel  <= !cs_n_s && !mr_n_s;
      reg_space_addr <= (!cs_n_s && !mr_n_s) ? addr_s : reg_space_addr;
    end
  end

  // AXI write path: address and data are taken independently
  logic        aw_got_reg;
  logic        w_got_reg;
  logic [7:0]  aw_idx_reg;
  logic        aw_ok_reg;
  logic [7:0]  wdat_reg;
  logic        wen_reg;
  logic        aw_fire;
  logic        w_fire;
  logic        aw_got_next;
  logic        w_got_next;
  logic        do_write;
  logic        bvalid_next;
  logic [7:0]  aw_idx;
  logic        aw_ok;

  assign aw_fire     = s_axi_awvalid && s_axi_awready;
  assign w_fire      = s_axi_wvalid && s_axi_wready;
  assign aw_got_next = aw_got_reg || aw_fire;
  assign w_got_next  = w_got_reg || w_fire;
  assign do_write    = aw_got_next && w_got_next && !s_axi_bvalid;
  assign bvalid_next = do_write || (s_axi_bvalid && !s_axi_bready);
  assign aw_idx      = s_axi_awaddr[9:2];
  assign aw_ok       = (s_axi_awaddr[HOST_ADDR_W-1:10] == '0)
                       && (aw_idx == IDX_MEM_CLK_CFG || aw_idx == IDX_PIX_CLK_CFG
                       || aw_idx == IDX_PULSE_MOD_CFG || aw_idx == IDX_CLK_SRC_SEL
                       || aw_idx == IDX_FUNC_ENABLE || aw_idx == IDX_PULSE_DUTY);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_got_reg    <= 1'b0;
      w_got_reg     <= 1'b0;
      aw_idx_reg    <= 8'h00;
      aw_ok_reg     <= 1'b0;
      wdat_reg      <= 8'h00;
      wen_reg       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else
    begin
      aw_got_reg    <= aw_got_next && !do_write;
      w_got_reg     <= w_got_next && !do_write;
      s_axi_awready <= !(aw_got_next && !do_write) && !bvalid_next;
      s_axi_wready  <= !(w_got_next && !do_write) && !bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (aw_fire)
      begin
        aw_idx_reg <= aw_idx;
        aw_ok_reg  <= aw_ok;
      end
      if (w_fire)
      begin
        wdat_reg <= s_axi_wdata[7:0];
        wen_reg  <= s_axi_wstrb[0];
      end
      if (do_write)
        s_axi_bresp <= (aw_fire ? aw_ok : aw_ok_reg) ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // Register update on the write cycle
  logic [7:0] wr_idx;
  logic [7:0] wr_dat;
  logic       wr_en;

  assign wr_idx = aw_fire ? aw_idx : aw_idx_reg;
  assign wr_dat = w_fire ? s_axi_wdata[7:0] : wdat_reg;
  assign wr_en  = do_write && (w_fire ? s_axi_wstrb[0] : wen_reg);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mem_cfg_reg   <= MEM_CLK_CFG_RST;
      pix_cfg_reg   <= PIX_CLK_CFG_RST;
      pulse_cfg_reg <= PULSE_MOD_CFG_RST;
      src_sel_reg   <= CLK_SRC_SEL_RST;
      fn_en_reg     <= FUNC_ENABLE_RST;
      duty_reg      <= PULSE_DUTY_RST;
    end
    else if (wr_en)
    begin
      if (wr_idx == IDX_MEM_CLK_CFG)   mem_cfg_reg   <= wr_dat;
      if (wr_idx == IDX_PIX_CLK_CFG)   pix_cfg_reg   <= wr_dat;
      if (wr_idx == IDX_PULSE_MOD_CFG) pulse_cfg_reg <= wr_dat;
      if (wr_idx == IDX_CLK_SRC_SEL)   src_sel_reg   <= wr_dat;
      if (wr_idx == IDX_FUNC_ENABLE)   fn_en_reg     <= wr_dat;
      if (wr_idx == IDX_PULSE_DUTY)    duty_reg      <= wr_dat;
    end
  end

  // AXI read path: one cycle of arready, data the cycle after
  logic [7:0] ar_idx;
  logic       ar_hi_ok;
  logic [7:0] status_word;
  logic [7:0] rd_mux;
  logic       rd_ok;
  logic       ar_fire;

  assign ar_idx      = s_axi_araddr[9:2];
  assign ar_hi_ok    = (s_axi_araddr[HOST_ADDR_W-1:10] == '0);
  assign status_word = {pulse_need, pix_need, mem_need, bus_need, 1'b0, strap_done_reg, strap_reg};
  assign rd_ok       = ar_hi_ok && (ar_idx == IDX_MEM_CLK_CFG || ar_idx == IDX_PIX_CLK_CFG
                       || ar_idx == IDX_PULSE_MOD_CFG || ar_idx == IDX_CLK_SRC_SEL
                       || ar_idx == IDX_FUNC_ENABLE || ar_idx == IDX_CLK_STATUS
                       || ar_idx == IDX_PULSE_DUTY);
  assign rd_mux      = !ar_hi_ok ? 8'h00 :
                       (ar_idx == IDX_MEM_CLK_CFG)   ? mem_cfg_reg :
                       (ar_idx == IDX_PIX_CLK_CFG)   ? pix_cfg_reg :
                       (ar_idx == IDX_PULSE_MOD_CFG) ? pulse_cfg_reg :
                       (ar_idx == IDX_CLK_SRC_SEL)   ? src_sel_reg :
                       (ar_idx == IDX_FUNC_ENABLE)   ? fn_en_reg :
                       (ar_idx == IDX_CLK_STATUS)    ? status_word :
                       (ar_idx == IDX_PULSE_DUTY)    ? duty_reg : 8'h00;
  assign ar_fire     = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (ar_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_mux};
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the clock tree, register space decode and write answer
  strap_fixed_a: assert property (@(posedge clk) disable iff (rst)
    strap_done_reg && $past(strap_done_reg) |-> $stable(strap_reg) && bus_ratio == 4'(strap_reg) + 4'h1)
    else $error("Bus divider not fixed by strap");

  bus_src_a: assert property (@(posedge clk) disable iff (rst)
    (bus_now == 4'h1 && !src_sel_reg[BUS_SRC_BIT] && pri_edge && bus_need) |=> bus_clk_en)
    else $error("Primary edge did not give bus clock");

  mem_gate_a: assert property (@(posedge clk) disable iff (rst)
    !mem_need |=> !mem_clk_en)
    else $error("Memory clock running while unneeded");

  pix_gate_a: assert property (@(posedge clk) disable iff (rst)
    !fn_en_reg[FN_PANEL_BIT] |=> !pix_clk_en)
    else $error("Pixel clock running without panel");

  pix_src_a: assert property (@(posedge clk) disable iff (rst)
    (pix_sel == PIX_SRC_PRI && pix_now == 4'h1 && pri_edge && pix_need) |=> pix_clk_en)
    else $error("Pixel clock missed primary edge");

  pulse_src_a: assert property (@(posedge clk) disable iff (rst)
    (!pulse_cfg_reg[PULSE_SRC_BIT] && pulse_now == 4'h1 && pri_edge && pulse_need) |=> ##1 pulse_mod_clock)
    else $error("Modulator clock missed primary edge");

  pulse_off_a: assert property (@(posedge clk) disable iff (rst)
    !pulse_need |=> !pulse_mod_output)
    else $error("Backlight output active while modulator gated");

  space_sel_a: assert property (@(posedge clk) disable iff (rst)
    (!cs_n_s && !mr_n_s) |=> reg_space_sel && reg_space_addr == $past(addr_s))
    else $error("Register space not selected");

  bresp_hold_a: assert property (@(posedge clk) disable iff (rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write answer dropped before taken");

  cov_panel_c: cover property (@(posedge clk) disable iff (rst) pix_clk_en && mem_clk_en);
  cov_div8_c: cover property (@(posedge clk) disable iff (rst) pix_now == PIX_DIV_8 && pix_clk_en);
  cov_crystal_osc_input_c: cover property (@(posedge clk) disable iff (rst) src_sel_reg[BUS_SRC_BIT] && bus_clk_en);
  cov_pwm_c: cover property (@(posedge clk) disable iff (rst) pulse_mod_output);
endmodule // lcd_clock_select

// file: design/lcd_clk_pkg.sv
package lcd_clk_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MEM_CLK_CFG   = 8'h04;
  localparam logic [7:0] IDX_PIX_CLK_CFG   = 8'h05;
  localparam logic [7:0] IDX_PULSE_MOD_CFG = 8'hb1;
  localparam logic [7:0] IDX_CLK_SRC_SEL   = 8'hca;
  localparam logic [7:0] IDX_FUNC_ENABLE   = 8'hf0;
  localparam logic [7:0] IDX_CLK_STATUS    = 8'hf1;
  localparam logic [7:0] IDX_PULSE_DUTY    = 8'hf2;

  // Field positions
  localparam int MEM_DIV_LSB      = 4;
  localparam int PIX_SRC_LSB      = 0;
  localparam int PIX_DIV_LSB      = 4;
  localparam int PULSE_SRC_BIT    = 0;
  localparam int BUS_SRC_BIT      = 0;
  localparam int SEC_SRC_BIT      = 1;
  localparam int FN_MEM_BIT       = 0;
  localparam int FN_LUT_BIT       = 1;
  localparam int FN_PANEL_BIT     = 2;
  localparam int FN_PULSE_BIT     = 3;
  localparam int FN_PSAVE_BIT     = 4;

  // Reset values
  localparam logic [7:0] MEM_CLK_CFG_RST   = 8'h00;
  localparam logic [7:0] PIX_CLK_CFG_RST   = 8'h00;
  localparam logic [7:0] PULSE_MOD_CFG_RST = 8'h00;
  localparam logic [7:0] CLK_SRC_SEL_RST   = 8'h00;
  localparam logic [7:0] FUNC_ENABLE_RST   = 8'h00;
  localparam logic [7:0] PULSE_DUTY_RST    = 8'h80;

  // Pixel source codes
  localparam logic [3:0] PIX_SRC_MEM = 4'h0;
  localparam logic [3:0] PIX_SRC_BUS = 4'h1;
  localparam logic [3:0] PIX_SRC_PRI = 4'h2;
  localparam logic [3:0] PIX_SRC_SEC = 4'h3;

  // Pixel divider codes
  localparam logic [3:0] PIX_DIV_CODE_MAX = 4'h3;
  localparam logic [3:0] PIX_DIV_CODE_8   = 4'h4;
  localparam logic [3:0] PIX_DIV_8        = 4'h8;

  // Host pin decode and strap capture
  localparam int          HOST_ADDR_W   = 17;
  localparam logic [1:0]  STRAP_WAIT    = 2'h3;

  // Bus answers
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// file: design/clk_div_tick.sv
`timescale 1ns/1ps
// Divides a stream of source pulses into one-cycle enable pulses
module clk_div_tick
  import lcd_clk_pkg::*;
#(
  parameter int CW = 4
)(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          src_tick,
  input  wire logic [CW-1:0] ratio_req,
  input  wire logic          gate_en,
  output logic               tick_q,
  output logic               raw_q,
  output logic [CW-1:0]      ratio_now
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] ratio_reg;
  logic          hit;

  // Terminal count of the current division period
  assign hit       = src_tick && (cnt_reg == CW'(ratio_reg - CW'(1)));
  assign ratio_now = ratio_reg;

  // New ratio only at a period boundary, so no shortened period appears
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg   <= '0;
      ratio_reg <= CW'(1);
      raw_q     <= 1'b0;
      tick_q    <= 1'b0;
    end
    else
    begin
      raw_q  <= hit;
      tick_q <= hit && gate_en;
      if (hit)
      begin
        cnt_reg   <= '0;
        ratio_reg <= ratio_req;
      end
      else if (src_tick)
        cnt_reg <= CW'(cnt_reg + CW'(1));
    end
  end

  ratio_edge_a: assert property (@(posedge clk) disable iff (rst)
    $changed(ratio_reg) |-> $past(hit))
    else $error("Divider ratio changed inside a period");

  tick_single_a: assert property (@(posedge clk) disable iff (rst)
    tick_q |=> !tick_q)
    else $error("Derived clock enable wider than one cycle");
endmodule // clk_div_tick

// file: dv/clk_src_model.sv
`timescale 1ns/1ps
// Free-running board oscillators at three distinct rates
module clk_src_model #(
  parameter int PP = 32,
  parameter int SP = 48,
  parameter int XP = 64
)(
  output logic pri,
  output logic sec,
  output logic xtl
);
  // Half periods are whole cycles, so no pin is level for under two cycles
  initial
  begin
    pri = 1'h0;
    sec = 1'h0;
    xtl = 1'h0;
  end
  always #(PP / 2) pri = ~pri;
  always #(SP / 2) sec = ~sec;
  always #(XP / 2) xtl = ~xtl;
endmodule // clk_src_model

// file: dv/lcd_ctrl_clock_select_tb_top.sv
`timescale 1ns/1ps
module lcd_ctrl_clock_select_tb_top;
  import lcd_clk_pkg::*;
  logic                   clk = 1'h0, rst = 1'h1;
  logic [HOST_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0, host_addr = '0, reg_space_addr;
  logic [31:0]            s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]             s_axi_wstrb = 4'hf;
  logic                   s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic                   s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, chip_select_n = 1'h1;
  logic                   mem_reg_select_n = 1'h1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic                   s_axi_arready, s_axi_rvalid, bus_clk_en, mem_clk_en, pix_clk_en;
  logic                   pulse_mod_clock, pulse_mod_output, reg_space_sel;
  logic                   primary_clock_input, secondary_clock_input, crystal_osc_input;
  logic [1:0]             s_axi_bresp, s_axi_rresp, strap_divider_select = 2'h0, r;
  logic [31:0]            d;
  int                     failures = 0, tests_run = 0, b, m, p, q;

  always #2 clk = ~clk;

  clk_src_model src (.pri(primary_clock_input), .sec(secondary_clock_input), .xtl(crystal_osc_input));

  lcd_clock_select uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .primary_clock_input, .secondary_clock_input, .crystal_osc_input,
    .strap_divider_select, .chip_select_n, .mem_reg_select_n, .host_addr, .bus_clk_en, .mem_clk_en,
    .pix_clk_en, .pulse_mod_clock, .pulse_mod_output, .reg_space_sel, .reg_space_addr);

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic hang;
    failures++;
    $display("BAD wait expected done got timeout");
    tally_and_finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Tick counts drift by one with the unrelated oscillator phase
  task automatic near(input string nm, input int e, input int g);
    tests_run++;
    if (g < e - 1 || g > e + 1)
    begin
      failures++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // Bus write: address and data offered together, bready held until bvalid
  task automatic wr(input logic [7:0] i, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_awaddr <= {7'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1 && n < 40);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    if (n >= 40) hang;
  endtask

  task automatic rd(input logic [7:0] i);
    int n;
    n = 0;
    @(posedge clk);
    s_axi_araddr <= {7'h0, i, 2'h0};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1 && n < 40);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    if (n >= 40) hang;
  endtask

  // Settle past any pending divider period, then count ticks over 480 cycles
  task automatic meas;
    b = 0; m = 0; p = 0; q = 0;
    repeat (160) @(posedge clk);
    repeat (480)
    begin
      @(posedge clk);
      b += int'(bus_clk_en === 1'h1);
      m += int'(mem_clk_en === 1'h1);
      p += int'(pix_clk_en === 1'h1);
      q += int'(pulse_mod_clock === 1'h1);
    end
  endtask

  task automatic t_strap;
    for (int s = 3; s >= 0; s--)
    begin
      @(posedge clk);
      rst <= 1'h1;
      strap_divider_select <= 2'(s);
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      repeat (8)
      begin
        @(posedge clk);
        chk("sel after reset", 32'h0, 32'(reg_space_sel));
      end
      rd(IDX_CLK_STATUS);
      chk("strap status", {29'h0, 1'h1, 2'(s)}, d & 32'h7);
      rd(IDX_PULSE_DUTY);
      chk("duty reset", 32'h80, d);
      wr(IDX_FUNC_ENABLE, 8'h10);
      meas;
      near("bus div", 60 / (s + 1), b);
      near("mem gated", 0, m);
    end
  endtask

  task automatic t_regs;
    wr(IDX_MEM_CLK_CFG, 8'h30);
    chk("wr resp", RESP_OKAY, r);
    s_axi_wstrb <= 4'h0;
    wr(IDX_MEM_CLK_CFG, 8'h10);
    chk("nostrb resp", RESP_OKAY, r);
    s_axi_wstrb <= 4'hf;
    rd(IDX_MEM_CLK_CFG);
    chk("mem cfg", 32'h30, d);
    wr(8'h33, 8'h55);
    chk("bad wr resp", RESP_SLVERR, r);
    rd(8'h33);
    chk("bad rd resp", RESP_SLVERR, r);
    chk("bad rd data", 32'h0, d);
  endtask

  task automatic wait_sel(input logic v);
    int n;
    n = 0;
    while (reg_space_sel !== v)
    begin
      @(posedge clk);
      n++;
      if (n > 20) hang;
    end
  endtask

  task automatic t_sel;
    chip_select_n <= 1'h0;
    mem_reg_select_n <= 1'h0;
    host_addr <= 17'h1abcd;
    wait_sel(1'h1);
    chk("reg addr", 32'h1abcd, 32'(reg_space_addr));
    mem_reg_select_n <= 1'h1;
    wait_sel(1'h0);
    chip_select_n <= 1'h1;
  endtask

  task automatic t_mem;
    for (int c = 0; c < 4; c++)
    begin
      wr(IDX_MEM_CLK_CFG, 8'(c << 4));
      wr(IDX_FUNC_ENABLE, 8'h01);
      meas;
      near("mem div", 60 / (c + 1), m);
      near("pix gated", 0, p);
    end
  endtask

  // Bus from crystal, memory at half of it, so every source differs except at k == 4, where the secondary also runs from crystal
  task automatic t_pix;
    logic [7:0] pc[11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h03, 8'h13, 8'h22, 8'h32, 8'h42, 8'h04, 8'h52};
    int pe[11] = '{15, 30, 60, 40, 30, 20, 20, 15, 7, 0, 60};
    wr(IDX_MEM_CLK_CFG, 8'h10);
    wr(IDX_FUNC_ENABLE, 8'h14);
    for (int k = 0; k < 11; k++)
    begin
      wr(IDX_CLK_SRC_SEL, (k == 4) ? 8'h03 : 8'h01);
      wr(IDX_PIX_CLK_CFG, pc[k]);
      meas;
      near("pix", pe[k], p);
      near("bus crystal_osc_input", 30, b);
    end
  endtask

  task automatic t_pwm;
    int w;
    wr(IDX_FUNC_ENABLE, 8'h08);
    for (int k = 0; k < 3; k++)
    begin
      wr(IDX_CLK_SRC_SEL, (k == 2) ? 8'h02 : 8'h00);
      wr(IDX_PULSE_MOD_CFG, (k == 0) ? 8'h00 : 8'h01);
      meas;
      near("pulse clk", (k == 0) ? 60 : (k == 1) ? 40 : 30, q);
      // One full modulator period at the reset duty: half of it high
      if (k == 0)
      begin
        w = 0;
        repeat (2048)
        begin
          @(posedge clk);
          w += int'(pulse_mod_output === 1'h1);
        end
        near("pwm high", 128, w / 8);
      end
    end
    wr(IDX_FUNC_ENABLE, 8'h00);
    meas;
    near("idle ticks", 0, b + m + p + q);
    chk("pwm idle", 32'h0, 32'(pulse_mod_output));
  endtask

  initial
  begin
    t_strap;
    t_regs;
    t_sel;
    t_mem;
    t_pix;
    t_pwm;
    tally_and_finish;
  end

  // Cut a hung run short
  initial
  begin
    #400000;
    hang;
  end
endmodule // lcd_ctrl_clock_select_tb_top
